/* File: core/ccmc_top.sv */
// converter configuration command handler and output mute control
// assumes fault, switchover and mode inputs come from logic on clk
`default_nettype none
module ccmc_top
   import ccmc_pkg::*;
#(
   parameter int NF = 4,
   parameter logic [31:0] MIN_KHZ = 32'h00593008,
   parameter logic [31:0] MAX_KHZ = 32'h006209a8,
   parameter logic [39:0] COLD_CYC = 40'(CCMC_COLD_CYC),
   parameter logic [39:0] WIN_CYC = 40'(CCMC_WIN_CYC),
   parameter logic [15:0] RETUNE_CYC = 16'(CCMC_RETUNE_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // unit options and redundancy
   input wire logic dual_if_fitted,
   input wire logic redundant_mode,
   input wire logic switchover,
   input wire logic primary_muted,
   // fault detectors, one level each
   input wire logic [NF-1:0] fault,
   // converter controls
   output logic rf_mute,
   output logic if_140,
   output logic [31:0] freq_khz,
   output logic [11:0] atten
);
   typedef struct packed {
      logic [31:0] freq;
      logic iff140;
      logic [11:0] att;
      logic [4:0] mode;
      logic mute;
      logic rej;
      logic lock;
      logic [15:0] rtn;
      logic [39:0] cold;
      logic [NF-1:0] fprev;
      logic [NF-1:0][2:0] fcnt;
      logic [NF-1:0][39:0] fwin;
      logic ack;
      logic [31:0] rdata;
      logic err;
      logic out;
   } ccmc_st_t;

   ccmc_st_t st_r;
   ccmc_st_t st_nxt;
   logic ph1;
   logic wr;
   logic mapped;
   logic ok_w;
   logic cold_act;
   logic any_fault;
   logic [NF-1:0] frise;

   // bus phases: one wait state so read data comes from a flop
   assign ph1 = psel & penable & ~st_r.ack;
   assign wr = psel & penable & pwrite & st_r.ack & ~st_r.err;
   assign any_fault = |fault;
   assign frise = fault & ~st_r.fprev;
   assign cold_act = st_r.mode[CCMC_M_COLD] & ~redundant_mode & (st_r.cold != COLD_CYC);

   // address decode and set-value checks
   always_comb begin
      mapped = 1'b1;
      ok_w = 1'b1;
      if (paddr == CCMC_OFF_FREQ) begin
         ok_w = (pwdata >= MIN_KHZ) && (pwdata <= MAX_KHZ) &&
            (st_r.mode[CCMC_M_FINE] || (pwdata % CCMC_FGRID) == 32'h0);
      end else if (paddr == CCMC_OFF_IFSEL) begin
         ok_w = dual_if_fitted && (pwdata == CCMC_IF_LO || pwdata == CCMC_IF_HI);
      end else if (paddr == CCMC_OFF_ATTEN) begin
         ok_w = (pwdata <= CCMC_ATT_MAX) && (pwdata % CCMC_ATT_STEP) == 32'h0;
      end else if (paddr == CCMC_OFF_MODE) begin
         ok_w = ~(redundant_mode & pwdata[CCMC_M_COLD]);
      end else if (paddr == CCMC_OFF_MUTE || paddr == CCMC_OFF_STAT) begin
         ok_w = 1'b1;
      end else begin
         mapped = 1'b0;
         ok_w = 1'b0;
      end
   end

   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.fprev = fault;
      st_nxt.ack = ph1;
      // cold counter runs once from each reset and then parks
      if (st_r.cold != COLD_CYC) begin
         st_nxt.cold = st_r.cold + 40'h1;
      end
      if (st_r.rtn != 16'h0) begin
         st_nxt.rtn = st_r.rtn - 16'h1;
      end
      // query form answers the current value
      if (ph1) begin
         st_nxt.err = ~mapped | (pwrite & ~ok_w);
         st_nxt.rdata = 32'h0;
         if (~pwrite) begin
            if (paddr == CCMC_OFF_FREQ) begin
               st_nxt.rdata = st_r.freq;
            end else if (paddr == CCMC_OFF_IFSEL) begin
               st_nxt.rdata = st_r.iff140 ? CCMC_IF_HI : CCMC_IF_LO;
            end else if (paddr == CCMC_OFF_ATTEN) begin
               st_nxt.rdata = {20'h0, st_r.att};
            end else if (paddr == CCMC_OFF_MODE) begin
               st_nxt.rdata = {27'h0, st_r.mode};
            end else if (paddr == CCMC_OFF_MUTE) begin
               st_nxt.rdata = {30'h0, cold_act ? CCMC_MQ_COLD : (st_r.mute ? CCMC_MQ_ON : CCMC_MQ_OFF)};
            end else if (paddr == CCMC_OFF_STAT) begin
               st_nxt.rdata = {26'h0, st_r.out, cold_act, any_fault, (st_r.rtn != 16'h0),
                  st_r.lock, st_r.rej};
            end
         end
      end
      // refused writes leave the setting and flag it
      if (psel & penable & pwrite & st_r.ack & st_r.err) begin
         st_nxt.rej = 1'b1;
      end
      // writes land on the completing edge only
      if (wr) begin
         if (paddr == CCMC_OFF_FREQ) begin
            st_nxt.freq = pwdata;
            if (~st_r.mode[CCMC_M_RETAIN]) begin
               st_nxt.rtn = RETUNE_CYC;
            end
         end else if (paddr == CCMC_OFF_IFSEL) begin
            st_nxt.iff140 = (pwdata == CCMC_IF_HI);
            // same muting as an rf retune
            if (~st_r.mode[CCMC_M_RETAIN]) begin
               st_nxt.rtn = RETUNE_CYC;
            end
         end else if (paddr == CCMC_OFF_ATTEN) begin
            st_nxt.att = pwdata[11:0];
         end else if (paddr == CCMC_OFF_MODE) begin
            st_nxt.mode = pwdata[4:0];
         end else if (paddr == CCMC_OFF_MUTE) begin
            st_nxt.mute = pwdata[0];
         end else if (paddr == CCMC_OFF_STAT) begin
            // write one to clear; a new event below wins
            if (pwdata[CCMC_S_REJ]) begin
               st_nxt.rej = 1'b0;
            end
            if (pwdata[CCMC_S_LOCK]) begin
               st_nxt.lock = 1'b0;
            end
         end
      end
      if (switchover) begin
         st_nxt.mute = st_r.mode[CCMC_M_REDMUTE] ? primary_muted : 1'b0;
      end
      // without recovery a fault latches the mute
      if (any_fault & ~st_r.mode[CCMC_M_AFR]) begin
         st_nxt.mute = 1'b1;
      end
      // per-fault repeat counting in a window
      for (int i = 0; i < NF; i++) begin
         if (st_r.fwin[i] != 40'h0) begin
            st_nxt.fwin[i] = st_r.fwin[i] - 40'h1;
         end else begin
            st_nxt.fcnt[i] = 3'h0;
         end
         if (frise[i] & st_r.mode[CCMC_M_AFR]) begin
            if (st_r.fwin[i] == 40'h0) begin
               st_nxt.fwin[i] = WIN_CYC - 40'h1;
               st_nxt.fcnt[i] = 3'h1;
            end else if (st_r.fcnt[i] == CCMC_FAULT_MAX) begin
               st_nxt.mode[CCMC_M_AFR] = 1'b0;
               st_nxt.mute = 1'b1;
               st_nxt.lock = 1'b1;
               st_nxt.fcnt[i] = 3'h0;
               st_nxt.fwin[i] = 40'h0;
            end else begin
               st_nxt.fcnt[i] = st_r.fcnt[i] + 3'h1;
            end
         end
      end
      st_nxt.out = st_nxt.mute | cold_act | (st_nxt.rtn != 16'h0) |
         (any_fault & st_r.mode[CCMC_M_AFR]);
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // start at the low frequency limit
         st_r.freq <= MIN_KHZ;
         st_r.iff140 <= 1'b0;
         st_r.att <= CCMC_ATT_RST;
         st_r.mode <= CCMC_MODE_RST;
         st_r.mute <= 1'b1;
         st_r.rej <= 1'b0;
         st_r.lock <= 1'b0;
         st_r.rtn <= 16'h0;
         st_r.cold <= 40'h0;
         st_r.fprev <= '0;
         st_r.fcnt <= '0;
         st_r.fwin <= '0;
         st_r.ack <= 1'b0;
         st_r.rdata <= 32'h0;
         st_r.err <= 1'b0;
         st_r.out <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign pready = st_r.ack;
   assign prdata = st_r.rdata;
   assign pslverr = st_r.ack & st_r.err;
   assign rf_mute = st_r.out;
   assign if_140 = st_r.iff140;
   assign freq_khz = st_r.freq;
   assign atten = st_r.att;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_query_freq: assert property (ph1 && !pwrite && paddr == CCMC_OFF_FREQ |=> prdata == $past(st_r.freq))
      else $error("frequency query answered a wrong value");
   a_freq_range: assert property (freq_khz >= MIN_KHZ && freq_khz <= MAX_KHZ)
      else $error("frequency outside limits");
   a_iff_guard: assert property (psel && penable && pwrite && st_r.ack && paddr == CCMC_OFF_IFSEL && !dual_if_fitted |=> $stable(if_140))
      else $error("if select changed on single-if unit");
   a_atten_grid: assert property (atten <= CCMC_ATT_MAX[11:0] && (atten % 12'h19) == 12'h0)
      else $error("attenuation off grid");
   a_cold_hold: assert property (cold_act |=> rf_mute)
      else $error("output live during cold start");
   a_retune_mute: assert property (wr && paddr == CCMC_OFF_FREQ && !st_r.mode[CCMC_M_RETAIN] |=> ##1 rf_mute [*2])
      else $error("no mute after retune");
   a_switch_free: assert property (switchover && !st_r.mode[CCMC_M_REDMUTE] && !any_fault |=> !st_r.mute)
      else $error("backup stayed muted");
   a_fault_mute: assert property (any_fault && st_r.mode[CCMC_M_AFR] |=> rf_mute)
      else $error("fault left output live");
   a_lockout: assert property ($rose(st_r.lock) |-> !st_r.mode[CCMC_M_AFR] && st_r.mute)
      else $error("lockout left recovery on");
   a_reject_keep: assert property (psel && penable && st_r.ack && pwrite && pslverr |=> $stable(atten) && $stable(freq_khz))
      else $error("refused write changed a setting");
endmodule
`default_nettype wire

/* File: core/ccmc_pkg.sv */
// constants of the converter configuration and mute block
// assumes a 250 MHz controller clock and an apb master
package ccmc_pkg;
   // clock and times
   localparam longint CCMC_CLK_HZ = 250_000_000;
   localparam longint CCMC_COLD_MIN = 15;
   localparam longint CCMC_COLD_CYC = CCMC_COLD_MIN * 60 * CCMC_CLK_HZ;
   localparam longint CCMC_WIN_MIN = 5;
   localparam longint CCMC_WIN_CYC = CCMC_WIN_MIN * 60 * CCMC_CLK_HZ;
   localparam longint CCMC_RETUNE_US = 100;
   localparam longint CCMC_RETUNE_CYC = CCMC_RETUNE_US * CCMC_CLK_HZ / 1_000_000;
   localparam logic [2:0] CCMC_FAULT_MAX = 3'h5;
   // register offsets
   localparam logic [7:0] CCMC_OFF_FREQ = 8'h00;
   localparam logic [7:0] CCMC_OFF_IFSEL = 8'h04;
   localparam logic [7:0] CCMC_OFF_ATTEN = 8'h08;
   localparam logic [7:0] CCMC_OFF_MODE = 8'h0c;
   localparam logic [7:0] CCMC_OFF_MUTE = 8'h10;
   localparam logic [7:0] CCMC_OFF_STAT = 8'h14;
   // value limits, kHz and hundredths of dB
   localparam logic [31:0] CCMC_FGRID = 32'h0000007d;
   localparam logic [31:0] CCMC_IF_LO = 32'h00000046;
   localparam logic [31:0] CCMC_IF_HI = 32'h0000008c;
   localparam logic [31:0] CCMC_ATT_MAX = 32'h000009c4;
   localparam logic [31:0] CCMC_ATT_STEP = 32'h00000019;
   localparam logic [11:0] CCMC_ATT_RST = 12'h3e8;
   // mode register bits
   localparam int CCMC_M_COLD = 0;
   localparam int CCMC_M_RETAIN = 1;
   localparam int CCMC_M_REDMUTE = 2;
   localparam int CCMC_M_AFR = 3;
   localparam int CCMC_M_FINE = 4;
   localparam logic [4:0] CCMC_MODE_RST = 5'h08;
   // mute query answers
   localparam logic [1:0] CCMC_MQ_OFF = 2'h0;
   localparam logic [1:0] CCMC_MQ_ON = 2'h1;
   localparam logic [1:0] CCMC_MQ_COLD = 2'h2;
   // status register bits
   localparam int CCMC_S_REJ = 0;
   localparam int CCMC_S_LOCK = 1;
endpackage

/* File: tb/ccmc_fault_src.sv */
// fault detector and switchover source beside the converter block
// assumes the bench calls its tasks at rising clock edges
`default_nettype none
module ccmc_fault_src (
   // clock
   input wire logic clk,
   // fault levels and switchover pulse
   output logic [3:0] fault,
   output logic switchover,
   output logic primary_muted
);
   timeunit 1ns;
   timeprecision 1ps;
   // detectors start healthy, no switchover pending
   initial begin
      fault = 4'h0;
      switchover = 1'b0;
      primary_muted = 1'b0;
   end
   // one detector level changed at the next edge
   task automatic set_fault(input int i, input logic v);
      @(posedge clk);
      fault[i] <= v;
   endtask
   // one-cycle switchover, primary state held steady across it
   task automatic swap(input logic pm);
      @(posedge clk);
      primary_muted <= pm;
      switchover <= 1'b1;
      @(posedge clk);
      switchover <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the converter block over apb
// assumes the fault source model and short cold and window counts
`default_nettype none
module testbench import ccmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, psel, penable, pwrite, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd, prdata, freq_khz;
   logic pready, pslverr, dual_if_fitted, redundant_mode;
   logic switchover, primary_muted, rf_mute, if_140;
   logic [3:0] fault;
   logic [11:0] atten;
   int fails = 0, cmp_count = 0, cyc = 0;
   ccmc_top #(.COLD_CYC(40'hc8), .WIN_CYC(40'h1f4), .RETUNE_CYC(16'ha)) u_ccmc_top (.clk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .dual_if_fitted, .redundant_mode,
      .switchover, .primary_muted, .fault, .rf_mute, .if_140, .freq_khz, .atten);
   ccmc_fault_src u_ccmc_fault_src (.clk, .fault, .switchover, .primary_muted);
   always #2 clk = ~clk;
   // hang guard, the whole run needs well under 3000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   // settle past the edge before looking at outputs
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
   endtask
   // apb master: request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready looked at once settled; the next edge completes the access
      do begin
         @(posedge clk);
         #1;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      xfer(1'b1, a, d);
      chk("pslverr", 32'(e), 32'(er));
   endtask
   task automatic rdv(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task automatic fin(input string t);
      $display("test %s done", t);
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      dual_if_fitted = 1'b0;
      redundant_mode = 1'b0;
      do_reset();
      chk("freq", 32'h00593008, freq_khz);
      chk("if_140", 32'h0, 32'(if_140));
      chk("atten", 32'h3e8, 32'(atten));
      chk("rf_mute", 32'h1, 32'(rf_mute));
      rdv("mode", CCMC_OFF_MODE, 32'h8);
      rdv("mute", CCMC_OFF_MUTE, 32'h1);
      fin("reset");
      wr(CCMC_OFF_ATTEN, 32'h9c4, 1'b0);
      wr(CCMC_OFF_ATTEN, 32'h9c5, 1'b1);
      wr(CCMC_OFF_ATTEN, 32'h9dd, 1'b1);
      rdv("atten", CCMC_OFF_ATTEN, 32'h9c4);
      chk("atten", 32'h9c4, 32'(atten));
      fin("atten");
      wr(CCMC_OFF_MUTE, 32'h0, 1'b0);
      wr(CCMC_OFF_IFSEL, 32'h8c, 1'b1);
      dual_if_fitted <= 1'b1;
      wr(CCMC_OFF_IFSEL, 32'h64, 1'b1);
      wr(CCMC_OFF_IFSEL, 32'h8c, 1'b0);
      cy(2);
      chk("if_140", 32'h1, 32'(if_140));
      chk("rf_mute", 32'h1, 32'(rf_mute));
      cy(12);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      rdv("ifsel", CCMC_OFF_IFSEL, 32'h8c);
      fin("ifsel");
      wr(CCMC_OFF_FREQ, 32'h005930b6, 1'b1);
      wr(CCMC_OFF_FREQ, 32'h00620ba5, 1'b1);
      wr(CCMC_OFF_FREQ, 32'h00593085, 1'b0);
      cy(2);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      cy(12);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      wr(CCMC_OFF_MODE, 32'h1a, 1'b0);
      wr(CCMC_OFF_FREQ, 32'h005930b6, 1'b0);
      cy(2);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      chk("freq", 32'h005930b6, freq_khz);
      fin("freq");
      u_ccmc_fault_src.set_fault(0, 1'b1);
      cy(2);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      u_ccmc_fault_src.set_fault(0, 1'b0);
      cy(2);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      wr(CCMC_OFF_MUTE, 32'h1, 1'b0);
      u_ccmc_fault_src.swap(1'b1);
      cy(2);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      wr(CCMC_OFF_MODE, 32'h0e, 1'b0);
      u_ccmc_fault_src.swap(1'b1);
      cy(2);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      u_ccmc_fault_src.swap(1'b0);
      cy(2);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      fin("fault and switchover");
      repeat (6) begin
         u_ccmc_fault_src.set_fault(1, 1'b1);
         u_ccmc_fault_src.set_fault(1, 1'b0);
      end
      cy(3);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      rdv("mode", CCMC_OFF_MODE, 32'h06);
      xfer(1'b0, CCMC_OFF_STAT, 32'h0);
      chk("lock", 32'h2, rd & 32'h2);
      wr(CCMC_OFF_MUTE, 32'h0, 1'b0);
      u_ccmc_fault_src.set_fault(2, 1'b1);
      u_ccmc_fault_src.set_fault(2, 1'b0);
      cy(3);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      wr(CCMC_OFF_MUTE, 32'h0, 1'b0);
      cy(2);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      wr(8'h18, 32'h0, 1'b1);
      wr(CCMC_OFF_STAT, 32'h3, 1'b0);
      rdv("stat", CCMC_OFF_STAT, 32'h0);
      redundant_mode <= 1'b1;
      wr(CCMC_OFF_MODE, 32'h09, 1'b1);
      redundant_mode <= 1'b0;
      fin("lockout");
      do_reset();
      wr(CCMC_OFF_MODE, 32'h09, 1'b0);
      rdv("mute", CCMC_OFF_MUTE, 32'h2);
      wr(CCMC_OFF_MUTE, 32'h0, 1'b0);
      cy(2);
      chk("rf_mute", 32'h1, 32'(rf_mute));
      cy(200);
      chk("rf_mute", 32'h0, 32'(rf_mute));
      rdv("mute", CCMC_OFF_MUTE, 32'h0);
      fin("cold start");
      wrap_up();
   end
endmodule
`default_nettype wire
